// *** common/gpa_defs.svh ***
// register indices, sub-register indices, reset values and port c mapping
`ifndef GPA_DEFS_SVH
`define GPA_DEFS_SVH
`define GPA_REG_INDEX 2'h0
`define GPA_REG_WINDOW 2'h1
`define GPA_REG_INPUT 2'h2
`define GPA_REG_OUTPUT 2'h3
`define GPA_SUB_DIR 8'h01
`define GPA_SUB_AF 8'h02
`define GPA_SUB_POC 8'h03
`define GPA_SUB_EDGE 8'h04
`define GPA_RST_INDEX 8'h00
`define GPA_RST_DIR 8'hff
`define GPA_RST_AF 8'h00
`define GPA_RST_POC 8'h00
`define GPA_RST_EDGE 8'h00
`define GPA_RST_OUT 8'h00
`define GPA_PC_TIMER_ONE_INPUT 0
`define GPA_PC_TIMER_ONE_OUTPUT 1
`define GPA_PC_SPI_SLAVE_SELECT 2
`define GPA_PC_SPI_SERIAL_CLOCK 3
`define GPA_PC_SPI_MOSI 4
`define GPA_PC_SPI_MISO 5
`endif

// *** common/gpa_pkg.sv ***
// types shared by the gpio port block
package gpa_pkg;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [1:0] addr;
		logic [7:0] wdata;
	} gpa_req_t;

	typedef struct packed {
		logic [7:0] value;
		logic [7:0] drive;
	} gpa_af_t;

	typedef struct packed {
		logic [7:0] index;
		logic [7:0] dir;
		logic [7:0] af;
		logic [7:0] poc;
		logic [7:0] edge_rise;
		logic [7:0] out;
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [7:0] prev;
		logic [7:0] rdata;
		logic [7:0] pin_out;
		logic [7:0] pin_oe;
		logic [7:0] irq;
	} gpa_state_t;
endpackage

// *** rtl/gpa_port.sv ***
// one 8-bit gpio port with sub-register window, open-drain and edge interrupts
`timescale 1ns/1ns
`include "gpa_defs.svh"

module gpa_port
	import gpa_pkg::*;
#(
	parameter logic [7:0] ANY_EDGE_MASK = 8'h00
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input gpa_req_t req,
	output logic [7:0] rdata,
	// pins
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	// alternate-function peripherals
	input gpa_af_t af,
	output logic [7:0] af_in,
	// interrupt requests, one-cycle pulses per pin
	output logic [7:0] irq
);
	gpa_state_t st;
	gpa_state_t next_st;
	logic [7:0] drive_en;
	logic [7:0] drive_val;
	logic [7:0] rise;
	logic [7:0] fall;
	logic [3:0] target;

	// one-hot window target: bit 0 direction, 1 alternate function, 2 open-drain, 3 edge select
	// an unused index selects nothing, so such writes are dropped and reads give zero
	function automatic logic [3:0] window_target(input logic [7:0] index);
		logic [3:0] hit;
		hit = 4'h0;
		if (index == `GPA_SUB_DIR) begin
			hit = 4'h1;
		end else if (index == `GPA_SUB_AF) begin
			hit = 4'h2;
		end else if (index == `GPA_SUB_POC) begin
			hit = 4'h4;
		end else if (index == `GPA_SUB_EDGE) begin
			hit = 4'h8;
		end
		return hit;
	endfunction

	always_comb begin
		next_st = st;
		// same decode serves window writes and window reads
		target = window_target(st.index);
		// second stage only: first stage feeds nothing else
		next_st.sync1 = pin_in;
		next_st.sync2 = st.sync1;
		next_st.prev = st.sync2;
		if (req.wr) begin
			if (req.addr == `GPA_REG_INDEX) begin
				next_st.index = req.wdata;
			end else if (req.addr == `GPA_REG_WINDOW) begin
				if (target[0]) begin
					next_st.dir = req.wdata;
				end
				if (target[1]) begin
					next_st.af = req.wdata;
				end
				if (target[2]) begin
					next_st.poc = req.wdata;
				end
				if (target[3]) begin
					next_st.edge_rise = req.wdata;
				end
			end else if (req.addr == `GPA_REG_OUTPUT) begin
				next_st.out = req.wdata;
			end
		end
		if (req.rd) begin
			next_st.rdata = 8'h00;
			if (req.addr == `GPA_REG_INDEX) begin
				next_st.rdata = st.index;
			end else if (req.addr == `GPA_REG_WINDOW) begin
				if (target[0]) begin
					next_st.rdata = st.dir;
				end
				if (target[1]) begin
					next_st.rdata = st.af;
				end
				if (target[2]) begin
					next_st.rdata = st.poc;
				end
				if (target[3]) begin
					next_st.rdata = st.edge_rise;
				end
			end else if (req.addr == `GPA_REG_INPUT) begin
				next_st.rdata = st.sync2;
			end else begin
				next_st.rdata = st.out;
			end
		end
		// peripheral owns the pin when selected, else direction bit (1 = input)
		drive_en = (st.af & af.drive) | (~st.af & ~st.dir);
		drive_val = (st.af & af.value) | (~st.af & st.out);
		// open-drain applies on top of the alternate-function drive, so peripheral-owned pins are open-drain too
		next_st.pin_oe = (st.poc & drive_en & ~drive_val) | (~st.poc & drive_en);
		next_st.pin_out = ~st.poc & drive_val;
		rise = st.sync2 & ~st.prev;
		fall = ~st.sync2 & st.prev;
		next_st.irq = (ANY_EDGE_MASK & (rise | fall))
			| (~ANY_EDGE_MASK & ((st.edge_rise & rise) | (~st.edge_rise & fall)));
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
			st.index <= `GPA_RST_INDEX;
			st.dir <= `GPA_RST_DIR;
			st.af <= `GPA_RST_AF;
			st.poc <= `GPA_RST_POC;
			st.edge_rise <= `GPA_RST_EDGE;
			st.out <= `GPA_RST_OUT;
			// synchroniser keeps shifting through reset, so the edge detector
			// starts from the pin's real level instead of a false edge
			st.sync1 <= pin_in;
			st.sync2 <= st.sync1;
			st.prev <= st.sync2;
		end else begin
			st <= next_st;
		end
	end

	assign rdata = st.rdata;
	assign pin_out = st.pin_out;
	assign pin_oe = st.pin_oe;
	assign irq = st.irq;
	// peripherals see the same synchronised level as software; port c wiring per pin
	// index follows the GPA_PC_* positions in the system top
	assign af_in = st.sync2;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_window_af_write: assert property (
		(req.wr && req.addr == `GPA_REG_WINDOW && st.index == `GPA_SUB_AF) |=> st.af == $past(req.wdata))
		else $error("alternate-function write through window lost");
	a_window_poc_route: assert property (
		(req.rd && !req.wr && req.addr == `GPA_REG_WINDOW && st.index == `GPA_SUB_POC) |=> rdata == $past(st.poc))
		else $error("open-drain select not read through window");
	a_index_write_lands: assert property (
		(req.wr && req.addr == `GPA_REG_INDEX) |=> st.index == $past(req.wdata))
		else $error("sub-register index write lost");
	a_index_steers_window: assert property (
		(req.rd && !req.wr && req.addr == `GPA_REG_WINDOW && st.index == `GPA_SUB_DIR)
			|=> rdata == $past(st.dir))
		else $error("index did not steer window to direction");
	a_input_sync_read: assert property (
		(req.rd && req.addr == `GPA_REG_INPUT) |=> rdata == $past(pin_in, 3))
		else $error("input levels read wrong");
	a_open_drain_low: assert property (
		(($past(st.poc) & pin_oe & pin_out) == 8'h00) && (($past(st.poc) & pin_out) == 8'h00))
		else $error("open-drain pin driven high");
	a_open_drain_af: assert property (
		(($past(st.poc & st.af) & (pin_oe ^ $past(af.drive & ~af.value))) == 8'h00))
		else $error("open-drain lost under alternate function");
	a_push_pull_drive: assert property (
		(($past(~st.poc & ~st.af) & ((pin_oe ^ $past(~st.dir)) | (pin_out ^ $past(st.out)))) == 8'h00))
		else $error("push-pull normal pin drive wrong");
	a_af_handover: assert property (
		(($past(~st.poc & st.af) & ((pin_oe ^ $past(af.drive)) | (pin_out ^ $past(af.value)))) == 8'h00))
		else $error("peripheral did not own pin");
	a_single_edge_irq: assert property (
		!$past(rst) |-> ((~ANY_EDGE_MASK & (irq ^ $past((st.edge_rise & st.sync2 & ~st.prev)
			| (~st.edge_rise & ~st.sync2 & st.prev)))) == 8'h00))
		else $error("single-edge request wrong");
	a_any_edge_irq: assert property (
		!$past(rst) |-> ((ANY_EDGE_MASK & (irq ^ $past(st.sync2 ^ st.prev))) == 8'h00))
		else $error("any-edge request wrong");
	a_reset_clears_sel: assert property (disable iff (1'b0)
		rst |=> (st.af == 8'h00 && st.poc == 8'h00 && pin_oe == 8'h00))
		else $error("reset left selects set");
	a_window_poc_write: assert property (
		(req.wr && req.addr == `GPA_REG_WINDOW && st.index == `GPA_SUB_POC) |=> st.poc == $past(req.wdata))
		else $error("open-drain select write through window lost");
	a_window_af_route: assert property (
		(req.rd && !req.wr && req.addr == `GPA_REG_WINDOW && st.index == `GPA_SUB_AF) |=> rdata == $past(st.af))
		else $error("alternate-function select not read through window");
	a_window_refuse: assert property (
		(req.rd && !req.wr && req.addr == `GPA_REG_WINDOW && (st.index == 8'h00 || st.index > `GPA_SUB_EDGE))
			|=> rdata == 8'h00)
		else $error("unused window index returned data");
	a_edge_sel_write: assert property (
		(req.wr && req.addr == `GPA_REG_WINDOW && st.index == `GPA_SUB_EDGE) |=> st.edge_rise == $past(req.wdata))
		else $error("edge select write through window lost");
	a_output_write_lands: assert property (
		(req.wr && req.addr == `GPA_REG_OUTPUT) |=> st.out == $past(req.wdata))
		else $error("output levels write lost");
	a_output_read: assert property (
		(req.rd && !req.wr && req.addr == `GPA_REG_OUTPUT) |=> rdata == $past(st.out))
		else $error("output levels read wrong");
	a_index_read_back: assert property (
		(req.rd && !req.wr && req.addr == `GPA_REG_INDEX) |=> rdata == $past(st.index))
		else $error("sub-register index read wrong");
	a_rdata_holds: assert property (
		!req.rd |=> rdata == $past(rdata))
		else $error("read data changed without a read");

	c_af_pin_driven: cover property ((st.af != 8'h00) ##1 (pin_oe != 8'h00));
	c_open_drain_low: cover property ((st.poc != 8'h00) ##1 ((pin_oe & ~pin_out) != 8'h00));
	c_edge_request: cover property (irq != 8'h00);
	c_window_poc_write: cover property (req.wr && req.addr == `GPA_REG_WINDOW && st.index == `GPA_SUB_POC);
	c_any_edge_request: cover property ((ANY_EDGE_MASK & irq) != 8'h00);
endmodule

// *** sim/gpa_pin_model.sv ***
// pin pads with external drivers and pull-ups
`timescale 1ns/1ns
module gpa_pin_model (
	// from the port
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	// external drivers
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	// resolved levels
	output logic [7:0] pin_in
);
	// pull-up, so a released open-drain pin reads high
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);
endmodule

// *** sim/gpio_port_altfunc_opendrain_tb_top.sv ***
// self-checking bench for the gpio port
`timescale 1ns/1ns
`include "gpa_defs.svh"
module gpio_port_altfunc_opendrain_tb_top;
	import gpa_pkg::*;
	logic clk = 0;
	logic rst = 1;
	gpa_req_t req = '0;
	gpa_af_t af = '0;
	logic [7:0] ext_en = 8'h00;
	logic [7:0] ext_val = 8'h00;
	logic [7:0] acc;
	logic [7:0] lvl;
	wire logic [7:0] rdata, pin_in, pin_out, pin_oe, af_in, irq;
	int failures = 0;
	int comparisons = 0;
	// dir af poc out afv afd, then expected oe and pin_out; af only on mapped bits 5..0
	logic [7:0] rows [5][8] = '{'{8'h00, 8'h00, 8'h00, 8'ha5, 8'h00, 8'h00, 8'hff, 8'ha5},
		'{8'h00, 8'h00, 8'hff, 8'ha5, 8'h00, 8'h00, 8'h5a, 8'h00},
		'{8'h00, 8'h3f, 8'h00, 8'ha5, 8'hcc, 8'hf0, 8'hf0, 8'h8c},
		'{8'h00, 8'h3f, 8'h0f, 8'ha5, 8'hcc, 8'hff, 8'hf3, 8'h80},
		'{8'hff, 8'h00, 8'h00, 8'ha5, 8'h00, 8'h00, 8'h00, 8'ha5}};
	gpa_port #(.ANY_EDGE_MASK(8'h80)) DUT (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .af(af), .af_in(af_in), .irq(irq));
	gpa_pin_model far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
	initial begin
		forever #5 clk = ~clk;
	end
	// hang guard
	initial begin
		#900000;
		failures++;
		finish_test();
	end
	task finish_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		req <= '0;
	endtask
	task rd(input logic [1:0] a, input logic [7:0] exp);
		@(posedge clk);
		req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		req <= '0;
		#1;
		chk(rdata, exp);
	endtask
	task sub(input logic [7:0] idx, input logic [7:0] v);
		wr(`GPA_REG_INDEX, idx);
		wr(`GPA_REG_WINDOW, v);
	endtask
	// irq pulses are one cycle wide, so gather them over a window
	task edge_chk(input logic [7:0] v, input logic [7:0] exp);
		@(posedge clk);
		ext_val <= v;
		acc = 8'h00;
		repeat (6) begin
			@(posedge clk);
			#1;
			acc |= irq;
		end
		chk(acc, exp);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		wr(`GPA_REG_INDEX, `GPA_SUB_AF);
		rd(`GPA_REG_WINDOW, `GPA_RST_AF);
		wr(`GPA_REG_INDEX, `GPA_SUB_POC);
		rd(`GPA_REG_WINDOW, `GPA_RST_POC);
		for (int i = 0; i < 5; i++) begin
			sub(`GPA_SUB_DIR, rows[i][0]);
			sub(`GPA_SUB_AF, rows[i][1]);
			sub(`GPA_SUB_POC, rows[i][2]);
			af <= '{rows[i][4], rows[i][5]};
			wr(`GPA_REG_OUTPUT, rows[i][3]);
			repeat (6) @(posedge clk);
			#1;
			chk(pin_oe, rows[i][6]);
			chk(pin_out, rows[i][7]);
			lvl = (rows[i][6] & rows[i][7]) | ~rows[i][6];
			chk(af_in, lvl);
			rd(`GPA_REG_INPUT, lvl);
			rd(`GPA_REG_WINDOW, rows[i][2]);
			wr(`GPA_REG_INDEX, `GPA_SUB_AF);
			rd(`GPA_REG_WINDOW, rows[i][1]);
			wr(`GPA_REG_INDEX, `GPA_SUB_DIR);
			rd(`GPA_REG_INDEX, `GPA_SUB_DIR);
			rd(`GPA_REG_WINDOW, rows[i][0]);
			rd(`GPA_REG_OUTPUT, rows[i][3]);
			$display("row %0d done", i);
		end
		wr(`GPA_REG_INDEX, 8'h05);
		wr(`GPA_REG_WINDOW, 8'hff);
		rd(`GPA_REG_WINDOW, 8'h00);
		wr(`GPA_REG_INDEX, `GPA_SUB_POC);
		rd(`GPA_REG_WINDOW, 8'h00);
		$display("window refusal done");
		@(posedge clk);
		ext_val <= 8'hff;
		ext_en <= 8'hff;
		repeat (6) @(posedge clk);
		edge_chk(8'h00, 8'hff);
		edge_chk(8'hff, 8'h80);
		sub(`GPA_SUB_EDGE, 8'hff);
		edge_chk(8'h00, 8'h80);
		edge_chk(8'hff, 8'hff);
		$display("edge interrupts done");
		sub(`GPA_SUB_POC, 8'hff);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		acc = 8'h00;
		repeat (4) begin
			@(posedge clk);
			#1;
			acc |= irq;
		end
		chk(acc, 8'h00);
		chk(pin_oe, 8'h00);
		wr(`GPA_REG_INDEX, `GPA_SUB_POC);
		rd(`GPA_REG_WINDOW, 8'h00);
		$display("mid-run reset done");
		finish_test();
	end
endmodule
